/* File: hw/ais_pkg.sv */
package ais_pkg;

    // register word addresses on the plain register port
    localparam logic [2:0] AIS_ADDR_INPUT_SELECT     = 3'h0;
    localparam logic [2:0] AIS_ADDR_PORT_CONFIG_LOW  = 3'h1;
    localparam logic [2:0] AIS_ADDR_PORT_CONFIG_HIGH = 3'h2;
    localparam logic [2:0] AIS_ADDR_SCAN_SELECT_LOW  = 3'h3;
    localparam logic [2:0] AIS_ADDR_CONTROL          = 3'h4;

    // input_select fields
    localparam int AIS_MUX_A_POS_LSB = 0;
    localparam int AIS_MUX_A_NEG_BIT = 7;
    localparam int AIS_MUX_B_POS_LSB = 8;
    localparam int AIS_MUX_B_NEG_BIT = 15;
    localparam logic [15:0] AIS_INPUT_SELECT_MASK = 16'h9f9f;

    // port_config_high fields
    localparam int AIS_HALF_BG_DIS_BIT = 0;
    localparam int AIS_BG_DIS_BIT      = 1;
    localparam logic [15:0] AIS_PORT_CONFIG_HIGH_MASK = 16'h0003;

    // control fields: alternate bit 0, scan enable bit 10, divider in bits 8-1 of the same word
    localparam int AIS_ALTERNATE_BIT = 0;
    localparam int AIS_SCAN_BIT      = 10;
    localparam logic [15:0] AIS_CONTROL_MASK = 16'h05ff;
    localparam int AIS_DIVIDER_LSB   = 1;

    // reset values
    localparam logic [15:0] AIS_RESET_VALUE = 16'h0000;

    // positive select encodings
    localparam logic [4:0] AIS_SEL_HALF_BANDGAP = 5'h10;
    localparam logic [4:0] AIS_SEL_BANDGAP      = 5'h11;

    // analog routing selection handed to the converter core
    typedef struct packed {
        logic [4:0] positive_select;
        logic       negative_is_input1;
    } ais_route_s;

    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] wdata;
        logic        write;
        logic        read;
    } ais_bus_s;

endpackage

/* File: hw/ais_input_select.sv */
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module ais_input_select
    import ais_pkg::*;
#(
    parameter int CHANNELS = 16
)
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    // register port
    input  wire ais_bus_s    bus_in,
    output logic [15:0]      rdata_out,
    // converter core handshake: one pulse per finished sample
    input  wire logic        sample_done_in,
    input  wire logic        converter_on_in,
    // routing to the sample and hold
    output ais_route_s       route_out,
    output logic             conv_clock_tick_out,
    output logic [CHANNELS-1:0] pin_digital_out,
    output logic [CHANNELS-1:0] pin_sample_enable_out
);

    // elaboration check: the register map serves sixteen analog pins only
    if (CHANNELS != 16)
    begin : g_channel_check
        $error("ais_input_select supports sixteen channels only");
    end

    // scan slots: 0-15 pins, 16 half band gap, 17 band gap
    localparam int         SLOT_COUNT = 18;
    localparam logic [4:0] SLOT_NONE  = 5'h1f;

    // bit positions of the write decode
    localparam int WR_INPUT_SELECT     = 0;
    localparam int WR_PORT_CONFIG_LOW  = 1;
    localparam int WR_PORT_CONFIG_HIGH = 2;
    localparam int WR_SCAN_SELECT_LOW  = 3;
    localparam int WR_CONTROL          = 4;

    // sample phase, Gray coded along first A, B, A, B ...
    typedef enum logic [1:0] {
        AIS_PH_FIRST_A = 2'b00,
        AIS_PH_B       = 2'b01,
        AIS_PH_A       = 2'b11
    } ais_phase_e;

    typedef struct packed {
        logic [15:0] input_select;
        logic [15:0] port_config_low;
        logic [1:0]  port_config_high;
        logic [15:0] scan_select_low;
        logic [10:0] control;
        logic [7:0]  divider;
        logic [7:0]  div_count;
        logic        tick;
        logic [4:0]  scan_pos;
        ais_phase_e  phase;
        logic [15:0] rdata;
        ais_route_s  route;
        logic [15:0] pin_digital;
        logic [15:0] pin_sample;
    } ais_state_s;

    ais_state_s state_reg;
    ais_state_s state_next;

    // next enabled scan slot above the current one; wraps to the lowest
    function automatic logic [4:0] next_slot
    (
        input logic [17:0] en,
        input logic [4:0]  cur
    );
        logic [4:0] found;
        logic       hit;
        found = cur;
        hit   = 1'b0;
        // first pass: nearest enabled slot above the current one
        for (int i = 0; i < SLOT_COUNT; i++)
        begin
            if (!hit && en[i] && 5'(i) > cur)
            begin
                found = 5'(i);
                hit   = 1'b1;
            end
        end
        // second pass: wrap to the lowest enabled slot
        for (int i = 0; i < SLOT_COUNT; i++)
        begin
            if (!hit && en[i])
            begin
                found = 5'(i);
                hit   = 1'b1;
            end
        end
        // no slot enabled: the position holds
        return found;
    endfunction

    // decoded controls and helpers of the next-state logic
    logic [17:0] scan_en;
    logic        scan_on;
    logic        alt_on;
    logic        use_b;
    logic        advance_scan;
    logic [4:0]  wr_sel;
    logic [15:0] read_word;
    logic [4:0]  pos_sel;
    logic        neg_sel;

    always_comb
    begin
        // every field holds unless a rule below moves it
        state_next   = state_reg;
        scan_on      = state_reg.control[AIS_SCAN_BIT];
        alt_on       = state_reg.control[AIS_ALTERNATE_BIT];
        use_b        = (state_reg.phase == AIS_PH_B);
        advance_scan = 1'b0;
        wr_sel       = 5'h00;
        read_word    = 16'h0000;
        pos_sel      = 5'h00;
        neg_sel      = 1'b0;

        // scan membership
        scan_en[17]   = ~state_reg.port_config_high[AIS_BG_DIS_BIT];
        scan_en[16]   = ~state_reg.port_config_high[AIS_HALF_BG_DIS_BIT];
        scan_en[15:0] = state_reg.scan_select_low;

        // write decode: one enable per register, none for unmapped addresses
        if (bus_in.write)
        begin
            case (bus_in.addr)
                AIS_ADDR_INPUT_SELECT:
                begin
                    wr_sel[WR_INPUT_SELECT] = 1'b1;
                end
                AIS_ADDR_PORT_CONFIG_LOW:
                begin
                    wr_sel[WR_PORT_CONFIG_LOW] = 1'b1;
                end
                AIS_ADDR_PORT_CONFIG_HIGH:
                begin
                    wr_sel[WR_PORT_CONFIG_HIGH] = 1'b1;
                end
                AIS_ADDR_SCAN_SELECT_LOW:
                begin
                    wr_sel[WR_SCAN_SELECT_LOW] = 1'b1;
                end
                AIS_ADDR_CONTROL:
                begin
                    wr_sel[WR_CONTROL] = 1'b1;
                end
                default:
                begin
                    wr_sel = 5'h00;
                end
            endcase
        end

        // register writes land at the edge that samples the strobe
        if (wr_sel[WR_INPUT_SELECT])
        begin
            // unimplemented bits 14-13 and 6-5 stay zero
            state_next.input_select = bus_in.wdata & AIS_INPUT_SELECT_MASK;
        end
        if (wr_sel[WR_PORT_CONFIG_LOW])
        begin
            state_next.port_config_low = bus_in.wdata;
        end
        if (wr_sel[WR_PORT_CONFIG_HIGH])
        begin
            state_next.port_config_high = bus_in.wdata[1:0];
        end
        if (wr_sel[WR_SCAN_SELECT_LOW])
        begin
            state_next.scan_select_low = bus_in.wdata;
        end
        if (wr_sel[WR_CONTROL])
        begin
            state_next.control[10]  = bus_in.wdata[AIS_SCAN_BIT];
            state_next.control[9:1] = 9'h000;
            state_next.control[0]   = bus_in.wdata[AIS_ALTERNATE_BIT];
            state_next.divider      = bus_in.wdata[AIS_DIVIDER_LSB +: 8];
        end

        // reads: the word stands in the cycle after the strobe, zero otherwise
        if (bus_in.read)
        begin
            case (bus_in.addr)
                AIS_ADDR_INPUT_SELECT:
                begin
                    read_word = state_reg.input_select;
                end
                AIS_ADDR_PORT_CONFIG_LOW:
                begin
                    read_word = state_reg.port_config_low;
                end
                AIS_ADDR_PORT_CONFIG_HIGH:
                begin
                    read_word = {14'h0000, state_reg.port_config_high};
                end
                AIS_ADDR_SCAN_SELECT_LOW:
                begin
                    read_word = state_reg.scan_select_low;
                end
                AIS_ADDR_CONTROL:
                begin
                    read_word[AIS_SCAN_BIT]         = state_reg.control[10];
                    read_word[AIS_DIVIDER_LSB +: 8] = state_reg.divider;
                    read_word[AIS_ALTERNATE_BIT]    = state_reg.control[0];
                end
                default:
                begin
                    read_word = 16'h0000;
                end
            endcase
        end
        state_next.rdata = read_word;

        // conversion clock: one tick every divider plus one system clocks
        if (state_reg.div_count >= state_reg.divider)
        begin
            state_next.div_count = 8'h00;
            state_next.tick      = 1'b1;
        end
        else
        begin
            state_next.div_count = state_reg.div_count + 8'h01;
            state_next.tick      = 1'b0;
        end

        // sample phase: an idle converter restarts on A
        if (!converter_on_in)
        begin
            state_next.phase = AIS_PH_FIRST_A;
        end
        else if (sample_done_in)
        begin
            case (state_reg.phase)
                AIS_PH_FIRST_A:
                begin
                    if (alt_on)
                    begin
                        state_next.phase = AIS_PH_B;
                    end
                    else
                    begin
                        state_next.phase = AIS_PH_FIRST_A;
                    end
                end
                AIS_PH_A:
                begin
                    if (alt_on)
                    begin
                        state_next.phase = AIS_PH_B;
                    end
                    else
                    begin
                        state_next.phase = AIS_PH_A;
                    end
                end
                AIS_PH_B:
                begin
                    state_next.phase = AIS_PH_A;
                end
                default:
                begin
                    state_next.phase = AIS_PH_FIRST_A;
                end
            endcase
        end

        // scan position: an idle converter parks it on the lowest enabled slot
        if (!converter_on_in)
        begin
            state_next.scan_pos = next_slot(scan_en, SLOT_NONE);
        end
        else if (sample_done_in && scan_on)
        begin
            // with alternation the scan steps on when the B sample finishes
            if (!alt_on || use_b)
            begin
                advance_scan = 1'b1;
            end
        end
        if (advance_scan)
        begin
            state_next.scan_pos = next_slot(scan_en, state_reg.scan_pos);
        end

        // routing for the sample in progress
        if (use_b)
        begin
            pos_sel = state_reg.input_select[AIS_MUX_B_POS_LSB +: 5];
            neg_sel = state_reg.input_select[AIS_MUX_B_NEG_BIT];
        end
        else if (scan_on)
        begin
            pos_sel = state_reg.scan_pos;
            neg_sel = state_reg.input_select[AIS_MUX_A_NEG_BIT];
        end
        else
        begin
            pos_sel = state_reg.input_select[AIS_MUX_A_POS_LSB +: 5];
            neg_sel = state_reg.input_select[AIS_MUX_A_NEG_BIT];
        end

        // codes 0-15 pick a pin, 10000 half band gap, 10001 band gap
        state_next.route.positive_select    = pos_sel;
        state_next.route.negative_is_input1 = neg_sel;

        // pin mode: one is digital with port reads, zero is analog and sampled
        state_next.pin_digital = state_reg.port_config_low;
        state_next.pin_sample  = ~state_reg.port_config_low;
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign rdata_out             = state_reg.rdata;
    assign route_out             = state_reg.route;
    assign conv_clock_tick_out   = state_reg.tick;
    assign pin_digital_out       = state_reg.pin_digital;
    assign pin_sample_enable_out = state_reg.pin_sample;

endmodule

`default_nettype wire

/* File: tb/ais_input_select_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module ais_input_select_sva
    import ais_pkg::*;
#(
    parameter int CHANNELS = 16
)
(
    // clock and reset
    input  wire logic                clock_in,
    input  wire logic                rstn_in,
    // register port
    input  wire ais_bus_s            bus_in,
    input  wire logic [15:0]         rdata_out,
    // converter side
    input  wire logic                sample_done_in,
    input  wire logic                converter_on_in,
    input  wire ais_route_s          route_out,
    input  wire logic                conv_clock_tick_out,
    input  wire logic [CHANNELS-1:0] pin_digital_out,
    input  wire logic [CHANNELS-1:0] pin_sample_enable_out
);
    localparam logic [15:0] MSK [5] = '{AIS_INPUT_SELECT_MASK, 16'hffff,
        AIS_PORT_CONFIG_HIGH_MASK, 16'hffff, AIS_CONTROL_MASK};
    logic [15:0] m [5];
    logic [15:0] rx;
    logic [8:0]  gap;
    logic [1:0]  sn;
    assign rx = (bus_in.addr < 3'h5) ? m[bus_in.addr] : 16'h0000;
    // register mirror
    always_ff @(posedge clock_in or negedge rstn_in)
        if (!rstn_in)
            m <= '{default: 16'h0000};
        else if (bus_in.write && bus_in.addr < 3'h5)
            m[bus_in.addr] <= bus_in.wdata & MSK[bus_in.addr];
    // tick spacing; sn counts ticks since the last write, holding at two
    always_ff @(posedge clock_in or negedge rstn_in)
        if (!rstn_in)
            {gap, sn} <= 11'h000;
        else
            {gap, sn} <= {conv_clock_tick_out ? 9'h001 : gap + 9'h001,
                bus_in.write ? 2'h0 : sn + {1'b0, conv_clock_tick_out && sn != 2'h2}};
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    sequence quiet_s;
        !sample_done_in && !bus_in.write && converter_on_in == $past(converter_on_in);
    endsequence
    rd_back_a: assert property (bus_in.read |=> rdata_out == $past(rx))
        else $error("read data differs from register");
    rd_idle_a: assert property (!bus_in.read |=> rdata_out == 16'h0000)
        else $error("read data outside read cycle");
    pin_mirror_a: assert property ($past(rstn_in) |->
        pin_digital_out == $past(m[1][CHANNELS-1:0])) else $error("pin mode wrong");
    pin_split_a: assert property ($past(rstn_in) |->
        pin_sample_enable_out == ~pin_digital_out) else $error("pin sample wrong");
    tick_gap_a: assert property (conv_clock_tick_out && sn == 2'h2 |->
        gap == {1'b0, m[4][8:1]} + 9'h001) else $error("tick spacing wrong");
    tick_once_a: assert property (conv_clock_tick_out && sn == 2'h2 &&
        m[4][8:1] != 8'h00 && !bus_in.write |=> !conv_clock_tick_out) else $error("tick long");
    mux_a_route_a: assert property (!converter_on_in && !$past(converter_on_in)
        && !$past(converter_on_in, 2) && !$past(m[4][10]) && !$past(m[4][10], 2)
        |-> route_out == {$past(m[0][4:0]), $past(m[0][7])}) else $error("route not A");
    route_hold_a: assert property (quiet_s [*3] |=> $stable(route_out))
        else $error("route moved without cause");
endmodule
bind ais_input_select ais_input_select_sva #(.CHANNELS(CHANNELS)) u_sva (
    .clock_in(clock_in), .rstn_in(rstn_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .sample_done_in(sample_done_in), .converter_on_in(converter_on_in),
    .route_out(route_out), .conv_clock_tick_out(conv_clock_tick_out),
    .pin_digital_out(pin_digital_out), .pin_sample_enable_out(pin_sample_enable_out));
`default_nettype wire

/* File: tb/ais_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ais_core_model
(
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rstn_in,
    // sample request and its length in clocks
    input  wire logic       start_in,
    input  wire logic [3:0] length_in,
    // one pulse per finished sample
    output logic            done_out
);
    logic [3:0] cnt;
    always_ff @(posedge clock_in or negedge rstn_in)
        if (!rstn_in)
            {cnt, done_out} <= 5'h00;
        else
            {cnt, done_out} <= {start_in ? cnt + {3'h0, cnt <= length_in} : 4'h0,
                start_in && cnt == length_in};
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import ais_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, conv = 1'b0, go = 1'b0, done, tick;
    logic [3:0] len = 4'h2;
    logic [15:0] rdata, pdig, pen;
    ais_bus_s b = '0;
    ais_route_s rt;
    int bad_count = 0, n_checks = 0, k;
    always #4 clk = ~clk;
    ais_input_select uut (.clock_in(clk), .rstn_in(rstn), .bus_in(b), .rdata_out(rdata),
        .sample_done_in(done), .converter_on_in(conv), .route_out(rt),
        .conv_clock_tick_out(tick), .pin_digital_out(pdig), .pin_sample_enable_out(pen));
    ais_core_model core (.clock_in(clk), .rstn_in(rstn), .start_in(go), .length_in(len),
        .done_out(done));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        {b.addr, b.wdata, b.write} <= {a, d, 1'b1};
        @(posedge clk);
        b.write <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        {b.addr, b.read} <= {a, 1'b1};
        @(posedge clk);
        b.read <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic rchk(input logic [5:0] e);
        repeat (2) @(posedge clk);
        #1 chk({10'h000, rt}, {10'h000, e});
    endtask
    task automatic smp(input logic [3:0] l);
        int i;
        @(posedge clk);
        {go, len} <= {1'b1, l};
        for (i = 0; i < 30 && done !== 1'b1; i++)
            @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic t_regs;
        for (k = 0; k < 6; k++)
            rd(k[2:0], AIS_RESET_VALUE);
        for (k = 0; k < 6; k++)
            wr(k[2:0], 16'hffff);
        rd(3'h0, AIS_INPUT_SELECT_MASK);
        rd(3'h2, AIS_PORT_CONFIG_HIGH_MASK);
        rd(3'h4, AIS_CONTROL_MASK);
        rd(3'h5, 16'h0000);
    endtask
    task automatic t_codes;
        wr(3'h4, 16'h0000);
        for (k = 0; k < 18; k++)
        begin
            wr(3'h0, {~k[0], 2'b00, 5'h0a, k[0], 2'b00, k[4:0]});
            rchk({k[4:0], k[0]});
        end
    endtask
    task automatic t_alt;
        wr(3'h4, 16'h0001);
        wr(3'h0, 16'h9110);
        @(posedge clk);
        conv <= 1'b1;
        rchk(6'h20);
        smp(4'h0);
        rchk(6'h23);
        smp(4'h9);
        rchk(6'h20);
    endtask
    task automatic t_scan;
        logic [4:0] sq [4] = '{5'h02, 5'h0f, 5'h10, 5'h00};
        @(posedge clk);
        conv <= 1'b0;
        wr(3'h2, 16'h0002);
        wr(3'h3, 16'h8005);
        wr(3'h4, 16'h0400);
        conv <= 1'b1;
        rchk(6'h00);
        for (k = 0; k < 4; k++)
        begin
            smp(4'h1);
            rchk({sq[k], 1'b0});
        end
        conv <= 1'b0;
    endtask
    task automatic t_misc;
        int n;
        wr(3'h1, 16'ha5c3);
        repeat (2) @(posedge clk);
        #1 chk(pdig, 16'ha5c3);
        chk(pen, 16'h5a3c);
        wr(3'h4, 16'h0006);
        repeat (300) @(posedge clk);
        for (n = 0; n < 20 && tick !== 1'b1; n++)
            @(posedge clk);
        @(posedge clk);
        for (n = 1; n < 20 && tick !== 1'b1; n++)
            @(posedge clk);
        chk(n[15:0], 16'h0004);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_codes;
        t_alt;
        t_scan;
        t_misc;
        end_sim;
    end
    initial
    begin
        #200000;
        bad_count++;
        end_sim;
    end
endmodule
`default_nettype wire
